// >>> pdlr_params.svh
// Purpose: Offsets, field positions and reset values of the port status/capability bank
// Assumes: APB byte addressing, one 32-bit word per register
// Notes: Printed offsets are not all word multiples, so they are indices
`ifndef PDLR_PARAMS_SVH
`define PDLR_PARAMS_SVH

`define PDLR_IDX_DEV_STATUS 12'h04a
`define PDLR_IDX_LINK_CAP 12'h04c
`define PDLR_IDX_DEV_CONTROL 12'h04b
`define PDLR_IDX_IRQ_STATUS 12'h060
`define PDLR_IDX_IRQ_MASK 12'h061
`define PDLR_ADDR_W 14

`define PDLR_ERR_FLAGS 4
`define PDLR_SPEED_LSB 0
`define PDLR_SPEED_MSB 3
`define PDLR_WIDTH_LSB 4
`define PDLR_WIDTH_MSB 9
`define PDLR_PMS_LSB 10
`define PDLR_PMS_MSB 11
`define PDLR_L0S_LSB 12
`define PDLR_L0S_MSB 14
`define PDLR_L1_LSB 15
`define PDLR_L1_MSB 17
`define PDLR_CLKPM_BIT 18
`define PDLR_SDOWN_BIT 19
`define PDLR_DLLA_BIT 20
`define PDLR_BWN_BIT 21
`define PDLR_PORT_LSB 24
`define PDLR_PORT_MSB 31

`define PDLR_SPEED_RST 4'h2
`define PDLR_WIDTH_RST 6'h04
`define PDLR_PMS_RST 2'h3
`define PDLR_L0S_RST 3'h6
`define PDLR_L1_RST 3'h2
`define PDLR_CLKPM_RST 1'h0
`define PDLR_MAX_PORT 8'h05

`endif

// >>> pdlr_pkg.sv
// Purpose: Types of the port status/capability bank
// Assumes: Nothing beyond the params header
// Notes: Width codes and APB slave states
package pdlr_pkg;
   typedef enum logic [5:0] {
      PDLR_W1 = 6'h01,
      PDLR_W2 = 6'h02,
      PDLR_W4 = 6'h04,
      PDLR_W8 = 6'h08
   } pdlr_width_t;

   typedef enum logic [2:0] {
      PDLR_IDLE = 3'b001,
      PDLR_ACCESS = 3'b010,
      PDLR_DONE = 3'b100
   } pdlr_apb_t;
endpackage

// >>> pdlr_err_flag.sv
// Purpose: One sticky error flag with write-one-to-clear
// Assumes: Detect pulse on core_clk
// Notes: Detection beats a clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
module pdlr_err_flag (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic detect,
   input wire logic clearOne,
   output logic flag
);
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         flag <= 1'b0;
      end else if (detect) begin
         flag <= 1'b1;
      end else if (clearOne) begin
         flag <= 1'b0;
      end
   end
endmodule // pdlr_err_flag
`default_nettype wire

// >>> pdlr_regs.sv
// Purpose: Device status and link capability registers of one switch port, APB slave
// Assumes: Error sources and register unlock come from logic on core_clk
// Notes: Register index times four is the byte address
//
// The APB register port was left to the implementer.
`include "pdlr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module pdlr_regs #(
   parameter logic [7:0] PORT_NUM = 8'h00,
   parameter bit IS_UPSTREAM = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`PDLR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic correctableDet,
   input wire logic nonfatalDet,
   input wire logic fatalDet,
   input wire logic unsupportedReqDet,
   input wire logic regUnlock,
   output logic correctableMsg,
   output logic [5:0] activeLinkWidth,
   output logic irq
);
   import pdlr_pkg::*;

   // Refused at elaboration: the index field only names the existing ports
   if (PORT_NUM > `PDLR_MAX_PORT) begin : gBadPort
      $error("PORT_NUM beyond last port");
   end

   pdlr_apb_t apbState_r;
   logic [31:0] prdata_nxt;
   logic decodeHit;
   logic wrStrobe;
   logic rdStrobe;
   logic [11:0] regIdx;
   logic [3:0] errFlags;
   logic [3:0] errDetect;
   logic [3:0] devControl_r;
   logic [5:0] linkWidth_r;
   logic [1:0] powerStateSupport_r;
   logic [2:0] standbyExitLatency_r;
   logic [2:0] deepIdleExitLatency_r;
   logic refclkRemovalCap_r;
   logic surpriseDownCap_r;
   logic linkActiveReportCap_r;
   logic bandwidthNotifyCap_r;
   logic [3:0] irqStatus_r;
   logic [3:0] irqMask_r;
   logic [15:0] devStatusWord;
   logic [31:0] linkCapWord;

   // Byte address to register index, low two bits ignored
   function automatic logic [11:0] addrToIdx(input logic [`PDLR_ADDR_W-1:0] a);
      return a[`PDLR_ADDR_W-1:2];
   endfunction

   function automatic logic isMapped(input logic [11:0] idx);
      return (idx == `PDLR_IDX_DEV_STATUS) || (idx == `PDLR_IDX_LINK_CAP) ||
             (idx == `PDLR_IDX_DEV_CONTROL) || (idx == `PDLR_IDX_IRQ_STATUS) ||
             (idx == `PDLR_IDX_IRQ_MASK);
   endfunction

   function automatic logic widthLegal(input logic [5:0] w);
      return (w == PDLR_W1) || (w == PDLR_W2) || (w == PDLR_W4) || (w == PDLR_W8);
   endfunction

   assign regIdx = addrToIdx(paddr);
   assign decodeHit = isMapped(regIdx);
   // Writes land on the access-phase edge only
   assign wrStrobe = psel && penable && pwrite && (apbState_r == PDLR_ACCESS);
   assign rdStrobe = psel && penable && !pwrite && (apbState_r == PDLR_ACCESS);

   // No wait state: setup, access (ready rises), done
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         apbState_r <= PDLR_IDLE;
      end else begin
         case (apbState_r)
            PDLR_IDLE: begin
               if (psel && !penable) begin
                  apbState_r <= PDLR_ACCESS;
               end
            end
            PDLR_ACCESS: begin
               apbState_r <= PDLR_DONE;
            end
            PDLR_DONE: begin
               apbState_r <= (psel && !penable) ? PDLR_ACCESS : PDLR_IDLE;
            end
            default: begin
               apbState_r <= PDLR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= (apbState_r == PDLR_IDLE || apbState_r == PDLR_DONE) && psel && !penable;
         pslverr <= (apbState_r == PDLR_IDLE || apbState_r == PDLR_DONE) && psel && !penable &&
                    !decodeHit;
      end
   end

   // Error flags; detection wins over a clear in the same cycle
   assign errDetect = {unsupportedReqDet, fatalDet, nonfatalDet, correctableDet};

   genvar g;
   generate
      for (g = 0; g < `PDLR_ERR_FLAGS; g++) begin : gFlag
         pdlr_err_flag uFlag (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .detect(errDetect[g]),
            .clearOne(pready && wrStrobe && regIdx == `PDLR_IDX_DEV_STATUS &&
                      pstrb[0] && pwdata[g]),
            .flag(errFlags[g])
         );
      end
   endgenerate

   // Plain read/write device control enables, bits 3:0
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         devControl_r <= 4'h0;
      end else if (pready && wrStrobe && regIdx == `PDLR_IDX_DEV_CONTROL && pstrb[0]) begin
         devControl_r <= pwdata[3:0];
      end
   end

   // Message forwarding gated by enable; status logging is not
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         correctableMsg <= 1'b0;
      end else begin
         correctableMsg <= correctableDet && devControl_r[0];
      end
   end

   // Link width field: software-owned, hardware never rewrites it
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         linkWidth_r <= `PDLR_WIDTH_RST;
      end else if (pready && wrStrobe && regIdx == `PDLR_IDX_LINK_CAP && pstrb[0] &&
                   pstrb[1] && regUnlock) begin
         linkWidth_r <= pwdata[`PDLR_WIDTH_MSB:`PDLR_WIDTH_LSB];
      end
   end

   // Narrowing only; an illegal or wider code falls back to the initial width
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         activeLinkWidth <= `PDLR_WIDTH_RST;
      end else if (widthLegal(linkWidth_r) && linkWidth_r <= `PDLR_WIDTH_RST) begin
         activeLinkWidth <= linkWidth_r;
      end else begin
         activeLinkWidth <= `PDLR_WIDTH_RST;
      end
   end

   // Lockable capability fields; downstream-only bits stay zero upstream
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         powerStateSupport_r <= `PDLR_PMS_RST;
         standbyExitLatency_r <= `PDLR_L0S_RST;
         deepIdleExitLatency_r <= `PDLR_L1_RST;
         refclkRemovalCap_r <= `PDLR_CLKPM_RST;
         surpriseDownCap_r <= !IS_UPSTREAM;
         linkActiveReportCap_r <= !IS_UPSTREAM;
         bandwidthNotifyCap_r <= !IS_UPSTREAM;
      end else if (pready && wrStrobe && regIdx == `PDLR_IDX_LINK_CAP && regUnlock) begin
         if (pstrb[1]) begin
            powerStateSupport_r <= pwdata[`PDLR_PMS_MSB:`PDLR_PMS_LSB];
            standbyExitLatency_r <= pwdata[`PDLR_L0S_MSB:`PDLR_L0S_LSB];
         end
         if (pstrb[1] && pstrb[2]) begin
            deepIdleExitLatency_r <= pwdata[`PDLR_L1_MSB:`PDLR_L1_LSB];
         end
         if (pstrb[2]) begin
            refclkRemovalCap_r <= pwdata[`PDLR_CLKPM_BIT];
            surpriseDownCap_r <= pwdata[`PDLR_SDOWN_BIT] && !IS_UPSTREAM;
            // Advertised only; this bank reports no link-active status
            linkActiveReportCap_r <= pwdata[`PDLR_DLLA_BIT] && !IS_UPSTREAM;
            bandwidthNotifyCap_r <= pwdata[`PDLR_BWN_BIT] && !IS_UPSTREAM;
         end
      end
   end

   // Interrupt status: set by detection, cleared by reading it
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irqStatus_r <= 4'h0;
      end else if (pready && rdStrobe && regIdx == `PDLR_IDX_IRQ_STATUS) begin
         irqStatus_r <= errDetect;
      end else begin
         irqStatus_r <= irqStatus_r | errDetect;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irqMask_r <= 4'h0;
      end else if (pready && wrStrobe && regIdx == `PDLR_IDX_IRQ_MASK && pstrb[0]) begin
         irqMask_r <= pwdata[3:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irqStatus_r | errDetect) & irqMask_r);
      end
   end

   // Read views; bits 4, 5 and reserved ranges are constant zero
   assign devStatusWord = {10'h000, 1'b0, 1'b0, errFlags};
   assign linkCapWord = {PORT_NUM, 2'h0, bandwidthNotifyCap_r, linkActiveReportCap_r,
                         surpriseDownCap_r, refclkRemovalCap_r, deepIdleExitLatency_r,
                         standbyExitLatency_r, powerStateSupport_r, linkWidth_r,
                         `PDLR_SPEED_RST};

   always_comb begin
      prdata_nxt = 32'h0000_0000;
      case (regIdx)
         `PDLR_IDX_DEV_STATUS: prdata_nxt = {16'h0000, devStatusWord};
         `PDLR_IDX_LINK_CAP: prdata_nxt = linkCapWord;
         `PDLR_IDX_DEV_CONTROL: prdata_nxt = {28'h0000000, devControl_r};
         `PDLR_IDX_IRQ_STATUS: prdata_nxt = {28'h0000000, irqStatus_r};
         `PDLR_IDX_IRQ_MASK: prdata_nxt = {28'h0000000, irqMask_r};
         default: prdata_nxt = 32'h0000_0000;
      endcase
   end

   // Captured with ready so data is stable in the access phase
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if ((apbState_r == PDLR_IDLE || apbState_r == PDLR_DONE) && psel && !penable &&
                   !pwrite) begin
         prdata <= prdata_nxt;
      end
   end
endmodule // pdlr_regs
`default_nettype wire

// >>> pdlr_regs_sva.sv
// Purpose: Bus and field checks on the status/capability bank
// Assumes: Read data valid while pready is high
// Notes: Bound to every instance of the bank
`include "pdlr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module pdlr_regs_sva #(
   parameter logic [7:0] PORT_NUM = 8'h00
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`PDLR_ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic correctableDet,
   input wire logic correctableMsg,
   input wire logic [5:0] activeLinkWidth,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire rdOk = pready && !pwrite;
   property p_answer; psel && !penable |=> pready; endproperty
   a_answer: assert property (p_answer)
      else $error("No answer after setup");
   property p_one_shot; pready |=> !pready; endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("Ready held too long");
   property p_err; pslverr |-> pready && !(paddr[13:2] inside
      {12'h04a, 12'h04b, 12'h04c, 12'h060, 12'h061}); endproperty
   a_err: assert property (p_err)
      else $error("Error on a mapped index");
   property p_sts_ro; rdOk && paddr == 14'h0128 |-> prdata[31:4] == 28'h0; endproperty
   a_sts_ro: assert property (p_sts_ro)
      else $error("Status upper bits not zero");
   property p_cap_ro; rdOk && paddr == 14'h0130 |-> prdata[3:0] == 4'h2
      && prdata[23:22] == 2'h0 && prdata[31:24] == PORT_NUM; endproperty
   a_cap_ro: assert property (p_cap_ro)
      else $error("Fixed capability fields wrong");
   property p_msg; correctableMsg |-> $past(correctableDet); endproperty
   a_msg: assert property (p_msg)
      else $error("Message without detect");
   property p_width; activeLinkWidth inside {6'h01, 6'h02, 6'h04}; endproperty
   a_width: assert property (p_width)
      else $error("Operating width not legal");
   property p_irq_fall; $fell(irq) |-> $past(pready) || $past(pready, 2); endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("Interrupt dropped without access");
endmodule // pdlr_regs_sva
bind pdlr_regs pdlr_regs_sva #(.PORT_NUM(PORT_NUM)) u_pdlr_regs_sva (.core_clk(core_clk),
   .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .correctableDet(correctableDet),
   .correctableMsg(correctableMsg), .activeLinkWidth(activeLinkWidth), .irq(irq));
`default_nettype wire

// >>> pdlr_regs_bench.sv
// Purpose: Self-checking bench for the status/capability bank
// Assumes: Downstream port 5 and upstream port 0 on one shared bus
// Notes: Status events reach both status registers
`include "pdlr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module pdlr_regs_bench;
   import pdlr_pkg::*;
   localparam logic [13:0] STS = 14'h0128, CTL = 14'h012c, CAP = 14'h0130;
   localparam logic [13:0] IS = 14'h0180, IM = 14'h0184;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, regUnlock = 1'b0;
   logic [13:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [31:0] prdataUp, qUp;
   logic [3:0] det = 4'h0, pstrb = 4'hf;
   logic pready, pslverr, correctableMsg, irq, err;
   logic [5:0] activeLinkWidth;
   logic [5:0] codes [5] = '{6'h01, 6'h02, 6'h08, 6'h03, 6'h00};
   logic [5:0] ops [5] = '{6'h01, 6'h02, 6'h04, 6'h04, 6'h04};
   int miscompares = 0, samples_checked = 0, cycles = 0;
   always #10 core_clk = ~core_clk;
   pdlr_regs #(.PORT_NUM(8'h05), .IS_UPSTREAM(1'b0)) u_pdlr_regs (.core_clk(core_clk),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .correctableDet(det[0]), .nonfatalDet(det[1]), .fatalDet(det[2]),
      .unsupportedReqDet(det[3]), .regUnlock(regUnlock), .correctableMsg(correctableMsg),
      .activeLinkWidth(activeLinkWidth), .irq(irq));
   // Upstream copy answers in step with the downstream one
   pdlr_regs #(.PORT_NUM(8'h00), .IS_UPSTREAM(1'b1)) u_pdlr_regs_up (.core_clk(core_clk),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdataUp), .pready(), .pslverr(),
      .correctableDet(det[0]), .nonfatalDet(det[1]), .fatalDet(det[2]),
      .unsupportedReqDet(det[3]), .regUnlock(regUnlock), .correctableMsg(),
      .activeLinkWidth(), .irq());
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Compares %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Ends when pready rises; if it never does, only the bench timeout ends this wait
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      qUp = prdataUp;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rc(input logic [13:0] a, input logic [31:0] e);
      apb(1'b0, a, '0);
      check(q, e);
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge core_clk);
      det <= m;
      @(posedge core_clk);
      det <= 4'h0;
      #1;
   endtask
   task automatic t_reset();
      rc(CAP, 32'h05396c42);
      check(qUp, 32'h00016c42);
      rc(STS, 32'h0);
      rc(14'h0100, 32'h0);
      check(err, 1'b1);
      check(activeLinkWidth, 6'h04);
      $display("t_reset done");
   endtask
   task automatic t_flags();
      pulse(4'hf);
      check(correctableMsg, 1'b0);
      rc(STS, 32'hf);
      pstrb <= 4'he;
      apb(1'b1, STS, 32'hf);
      pstrb <= 4'hf;
      rc(STS, 32'hf);
      apb(1'b1, STS, 32'h35);
      rc(STS, 32'ha);
      apb(1'b1, STS, 32'hffffffff);
      rc(STS, 32'h0);
      apb(1'b1, CTL, 32'h1);
      pulse(4'h1);
      check(correctableMsg, 1'b1);
      rc(STS, 32'h1);
      apb(1'b1, CTL, 32'h0);
      $display("t_flags done");
   endtask
   task automatic t_lock();
      apb(1'b1, CAP, 32'h0);
      rc(CAP, 32'h05396c42);
      check(qUp, 32'h00016c42);
      regUnlock <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, CAP, 32'hfffffc0f | {codes[i], 4'h0});
         rc(CAP, 32'h053ffc02 | {codes[i], 4'h0});
         check(qUp, 32'h0007fc02 | {codes[i], 4'h0});
         check(activeLinkWidth, ops[i]);
      end
      regUnlock <= 1'b0;
      apb(1'b1, CAP, 32'h0);
      rc(CAP, 32'h053ffc02);
      check(qUp, 32'h0007fc02);
      $display("t_lock done");
   endtask
   task automatic t_irq();
      rc(IS, 32'hf);
      rc(IS, 32'h0);
      apb(1'b1, IM, 32'h4);
      pulse(4'h4);
      @(posedge core_clk);
      #1 check(irq, 1'b1);
      pulse(4'h2);
      rc(IS, 32'h6);
      @(posedge core_clk);
      #1 check(irq, 1'b0);
      apb(1'b1, IM, 32'h0);
      pulse(4'h8);
      @(posedge core_clk);
      #1 check(irq, 1'b0);
      rc(IM, 32'h0);
      $display("t_irq done");
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset();
      t_flags();
      t_lock();
      t_irq();
      finish_test();
   end
endmodule // pdlr_regs_bench
`default_nettype wire
